// ---- pxa_core.sv ----
// Pixel accelerator datapath, sequencer and register port.
// Assumes a master that holds strobes one cycle and reads data in the following cycle.
//
// Functional notes
// RULE_01: Shifter works on both carry halves; unmasked output lands in destination word.
// RULE_02: Alignment shifts only left to right; no reverse shift path.
// RULE_03: Every operation leaves its result in the destination word register.
// RULE_04: Copy writes each source pixel over its destination pixel.
// RULE_05: Patch copies, but transparent source pixels leave destination unchanged.
// RULE_06: Source pixel is transparent when it equals the key colour.
// RULE_07: Exchange interchanges source and destination pixels, both results readable.
// RULE_08: Swap exchanges like exchange but skips transparent source pixels.
// RULE_09: Command bit selects inverted sequence giving apparent right-to-left shift.
// RULE_10: Foreground paint sets non-transparent positions to foreground; others unchanged.
// RULE_11: Foreground/background paint sets transparent positions to background.
// RULE_12: Bit expand: 1 gives foreground, 0 unchanged; index auto-increments.
// RULE_13: Bit expand background: 0 gives background colour.
// RULE_14: Source nibbles are consumed leftmost first across triggers.
// RULE_15: Basic 4bpp expansion or shrink 8bpp consumes one nibble per trigger.
// RULE_16: Zoom 8bpp consumes one source bit per trigger, MSB first.
// RULE_17: Compare puts per-pixel results in leftmost destination nibble.
// RULE_18: Packed test writes indexed nibble, increments index, protects earlier nibbles.
// RULE_19: At 8bpp two duplicated bits per trigger; second trigger completes nibble.
// RULE_20: Writing source or destination word triggers, depending on operation.
// RULE_21: Destination-triggered copy: load source, destination write triggers.
// RULE_22: Source-triggered copy: load destination, source write triggers.
// RULE_23: Exchange alternates source and destination words through source register.
// RULE_24: Implicit select routes writes to trigger register, reads to destination.
// RULE_25: Implicit reads return destination word; writes go to trigger register.
// RULE_26: System drives implicit select from high-order address decode.
// RULE_27: Each triggered operation completes well inside sixteen slots.
// RULE_28: Datapath holds source, split 32-bit carry, shifter and destination words.
// RULE_29: Test bit is 1 for key match; unused compare nibbles read zero.
// RULE_30: Writing the command register returns the nibble index to leftmost.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "pxa_regs.svh"

module pxa_core
    import pxa_pkg::*;
(
    input  wire logic         mclk,                    // 100 MHz clock
    input  wire logic         reset_n,                 // Synchronous reset, active low
    input  wire pxa_bus_req_t bus_req,                 // Register port request
    input  wire logic         implicit_access_select,  // Implicit access qualifier
    output logic      [15:0]  rd_data,                 // Read data, cycle after read strobe
    output logic              pixac_busy               // Operation in progress
);
    pxa_state_t  st_reg;
    pxa_state_t  st_next;
    logic [31:0] carry_pair;
    logic [15:0] aligned;
    logic [15:0] res4;
    logic [15:0] res8;
    logic [15:0] combined;
    logic [3:0]  t4;
    logic [1:0]  t8;
    logic [3:0]  expb4;
    logic [1:0]  expb8;
    logic [4:0]  bits_per_trig;
    logic        trig_on_src;
    logic        wr_src;
    logic        wr_dst;
    logic        trigger;
    logic [3:0]  test_nib;
    logic [15:0] packed_word;

    // ----------------------------------------------------------------
    // Alignment
    // ----------------------------------------------------------------
    // RULE_01: shifter on carry pair
    // RULE_02: right shift only
    // RULE_28: split carry register
    assign carry_pair = {st_reg.carry_upper_half, st_reg.carry_lower_half};
    assign aligned    = 16'(carry_pair >> {st_reg.shift, 2'b00});

    // ----------------------------------------------------------------
    // Bit expansion pacing
    // ----------------------------------------------------------------
    // Bits per trigger: pixels per word, halved by zoom, doubled by shrink
    always_comb begin
        bits_per_trig = st_reg.cmd.bpp8 ? 5'h02 : 5'h04;
        if (st_reg.cmd.zoom2) begin
            bits_per_trig = bits_per_trig >> 1;
        end
        if (st_reg.cmd.shrink2) begin
            bits_per_trig = bits_per_trig << 1;
        end
    end

    // ----------------------------------------------------------------
    // Pixel lanes
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_lane4
        localparam logic [4:0] J4 = 5'(i);
        logic [4:0] prod4;
        logic [3:0] pos4;
        assign prod4    = J4 * bits_per_trig;
        assign pos4     = 4'(st_reg.bit_idx + prod4[4:2]);
        assign expb4[i] = st_reg.src_word[4'hF - pos4];
        pxa_pixel_lane #(.W(4)) u_lane (
            .op     (st_reg.cmd.op),
            .phase  (st_reg.xch_phase),
            .src    (aligned[15-4*i -: 4]),
            .dst    (st_reg.dst_word[15-4*i -: 4]),
            .hold   (st_reg.hold_word[15-4*i -: 4]),
            .key    (st_reg.transparent_key_reg),
            .fg     (st_reg.foreground_shade_reg),
            .bg     (st_reg.background_shade_reg),
            .expbit (expb4[i]),
            .res    (res4[15-4*i -: 4]),
            .transp (t4[3-i])
        );
    end

    for (genvar i = 0; i < 2; i++) begin : g_lane8
        localparam logic [4:0] J8 = 5'(i);
        logic [4:0] prod8;
        logic [3:0] pos8;
        assign prod8    = J8 * bits_per_trig;
        assign pos8     = 4'(st_reg.bit_idx + prod8[4:1]);
        assign expb8[i] = st_reg.src_word[4'hF - pos8];
        pxa_pixel_lane #(.W(8)) u_lane (
            .op     (st_reg.cmd.op),
            .phase  (st_reg.xch_phase),
            .src    (aligned[15-8*i -: 8]),
            .dst    (st_reg.dst_word[15-8*i -: 8]),
            .hold   (st_reg.hold_word[15-8*i -: 8]),
            .key    (st_reg.transparent_key_reg),
            .fg     (st_reg.foreground_shade_reg),
            .bg     (st_reg.background_shade_reg),
            .expbit (expb8[i]),
            .res    (res8[15-8*i -: 8]),
            .transp (t8[1-i])
        );
    end

    // ----------------------------------------------------------------
    // Transparency test packing
    // ----------------------------------------------------------------
    // RULE_19: 8bpp pairs duplicated, second half completes
    // RULE_29: one means key match
    always_comb begin
        if (!st_reg.cmd.bpp8) begin
            test_nib = t4;
        end else if (!st_reg.half_sel) begin
            test_nib = {t8, t8};
        end else begin
            test_nib = {st_reg.dst_word[15 - 4*st_reg.nib_idx -: 2], t8};
        end
        // RULE_18: earlier nibbles kept
        packed_word = st_reg.dst_word;
        packed_word[15 - 4*st_reg.nib_idx -: 4] = test_nib;
    end

    // Mask bits set to 1 protect the destination bit
    assign combined = ((st_reg.cmd.bpp8 ? res8 : res4) & ~st_reg.mask) | (st_reg.dst_word & st_reg.mask);

    // ----------------------------------------------------------------
    // Register port and sequencer
    // ----------------------------------------------------------------
    // RULE_20: trigger register by operation
    // RULE_21: copy variants pick trigger
    // RULE_22: source trigger variant
    assign trig_on_src = (st_reg.cmd.op == `PXA_OP_EXCH) || (st_reg.cmd.op == `PXA_OP_SWAP)
                      || (st_reg.cmd.op == `PXA_OP_COMPARE) || (st_reg.cmd.op == `PXA_OP_PACKED)
                      || (((st_reg.cmd.op == `PXA_OP_COPY) || (st_reg.cmd.op == `PXA_OP_PATCH))
                          && st_reg.cmd.src_trig);

    // RULE_24: implicit write routing
    // RULE_25: implicit target choice
    // Data writes while running are dropped so an operand cannot change under the combine
    assign wr_src  = bus_req.wr && (st_reg.seq == PXA_IDLE)
                  && (implicit_access_select ? trig_on_src : (bus_req.addr == `PXA_OFF_SRC));
    assign wr_dst  = bus_req.wr && (st_reg.seq == PXA_IDLE)
                  && (implicit_access_select ? !trig_on_src : (bus_req.addr == `PXA_OFF_DST));
    assign trigger = (wr_src && trig_on_src) || (wr_dst && !trig_on_src);

    always_comb begin
        st_next       = st_reg;
        st_next.rdata = 16'h0000;

        case (st_reg.seq)
            PXA_IDLE: begin
                if (trigger) begin
                    st_next.seq = PXA_RUN;
                end
            end
            PXA_RUN: begin
                // RULE_27: single cycle run
                st_next.seq = PXA_IDLE;
                // RULE_03: result into destination
                case (st_reg.cmd.op)
                    `PXA_OP_COMPARE: begin
                        // RULE_17: leftmost nibble result
                        st_next.dst_word = {test_nib, 12'h000};
                        if (st_reg.cmd.bpp8) begin
                            st_next.half_sel = !st_reg.half_sel;
                        end
                    end
                    `PXA_OP_PACKED: begin
                        st_next.dst_word = packed_word;
                        if (!st_reg.cmd.bpp8 || st_reg.half_sel) begin
                            st_next.nib_idx = 2'(st_reg.nib_idx + 2'h1);
                        end
                        if (st_reg.cmd.bpp8) begin
                            st_next.half_sel = !st_reg.half_sel;
                        end
                    end
                    `PXA_OP_BEXP_FG, `PXA_OP_BEXP_BG: begin
                        st_next.dst_word = combined;
                        // RULE_14: leftmost first
                        // RULE_15: nibble per trigger
                        // RULE_16: bit per trigger
                        st_next.bit_idx  = 4'(st_reg.bit_idx + bits_per_trig[3:0]);
                    end
                    `PXA_OP_EXCH, `PXA_OP_SWAP: begin
                        // RULE_23: alternate word phases
                        st_next.dst_word  = combined;
                        st_next.xch_phase = !st_reg.xch_phase;
                        if (!st_reg.xch_phase) begin
                            st_next.hold_word = aligned;
                        end
                    end
                    default: begin
                        st_next.dst_word = combined;
                    end
                endcase
            end
            default: begin
                st_next.seq = PXA_IDLE;
            end
        endcase

        if (wr_src) begin
            st_next.src_word = bus_req.wdata;
            // RULE_09: inverted load order
            if (st_reg.cmd.invert) begin
                st_next.carry_lower_half = st_reg.carry_upper_half;
                st_next.carry_upper_half = bus_req.wdata;
            end else begin
                st_next.carry_upper_half = st_reg.carry_lower_half;
                st_next.carry_lower_half = bus_req.wdata;
            end
        end
        if (wr_dst) begin
            st_next.dst_word = bus_req.wdata;
        end

        if (bus_req.wr && !implicit_access_select) begin
            case (bus_req.addr)
                `PXA_OFF_CMD: begin
                    st_next.cmd       = bus_req.wdata;
                    // RULE_30: new command resets index
                    st_next.bit_idx   = 4'h0;
                    st_next.nib_idx   = 2'h0;
                    st_next.half_sel  = 1'b0;
                    st_next.xch_phase = 1'b0;
                end
                `PXA_OFF_KEY:   st_next.transparent_key_reg  = bus_req.wdata[7:0];
                `PXA_OFF_FG:    st_next.foreground_shade_reg = bus_req.wdata[7:0];
                `PXA_OFF_BG:    st_next.background_shade_reg = bus_req.wdata[7:0];
                `PXA_OFF_SHIFT: st_next.shift                = bus_req.wdata[1:0];
                `PXA_OFF_MASK:  st_next.mask                 = bus_req.wdata;
                default:        st_next.mask                 = st_next.mask;
            endcase
        end

        if (bus_req.rd) begin
            if (implicit_access_select) begin
                st_next.rdata = st_reg.dst_word;
            end else begin
                case (bus_req.addr)
                    `PXA_OFF_SRC:    st_next.rdata = st_reg.src_word;
                    `PXA_OFF_DST:    st_next.rdata = st_reg.dst_word;
                    `PXA_OFF_CMD:    st_next.rdata = st_reg.cmd;
                    `PXA_OFF_KEY:    st_next.rdata = {8'h00, st_reg.transparent_key_reg};
                    `PXA_OFF_FG:     st_next.rdata = {8'h00, st_reg.foreground_shade_reg};
                    `PXA_OFF_BG:     st_next.rdata = {8'h00, st_reg.background_shade_reg};
                    `PXA_OFF_SHIFT:  st_next.rdata = {14'h0000, st_reg.shift};
                    `PXA_OFF_MASK:   st_next.rdata = st_reg.mask;
                    `PXA_OFF_STATUS: st_next.rdata = {7'h00, st_reg.seq == PXA_RUN, st_reg.xch_phase,
                                                      st_reg.half_sel, st_reg.nib_idx, st_reg.bit_idx};
                    default:         st_next.rdata = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg                      <= '0;
            st_reg.seq                  <= PXA_IDLE;
            st_reg.src_word             <= `PXA_RST_WORD;
            st_reg.dst_word             <= `PXA_RST_WORD;
            st_reg.mask                 <= `PXA_RST_WORD;
            st_reg.transparent_key_reg  <= `PXA_RST_SHADE;
            st_reg.foreground_shade_reg <= `PXA_RST_SHADE;
            st_reg.background_shade_reg <= `PXA_RST_SHADE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data    = st_reg.rdata;
    assign pixac_busy = (st_reg.seq == PXA_RUN);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_trig;
        trigger && (st_reg.seq == PXA_IDLE);
    endsequence

    sequence s_done;
        (st_reg.seq == PXA_RUN) ##1 (st_reg.seq == PXA_IDLE);
    endsequence

    trigger_starts_run_a: assert property (s_trig |=> s_done) // RULE_20
        else $error("trigger did not run one cycle then idle");

    run_within_slots_a: assert property (st_reg.seq == PXA_RUN |=> st_reg.seq == PXA_IDLE) // RULE_27
        else $error("operation exceeded its cycle budget");

    copy_result_a: assert property (st_reg.seq == PXA_RUN && st_reg.cmd.op == `PXA_OP_COPY // RULE_04
        && !st_reg.cmd.bpp8 && st_reg.mask == 16'h0000 && !bus_req.wr |=> st_reg.dst_word == $past(aligned))
        else $error("copy result differs from aligned source");

    cmd_index_reset_a: assert property (bus_req.wr && !implicit_access_select // RULE_30
        && bus_req.addr == `PXA_OFF_CMD |=> st_reg.bit_idx == 4'h0 && st_reg.nib_idx == 2'h0)
        else $error("command write left index nonzero");

    compare_clears_a: assert property (st_reg.seq == PXA_RUN // RULE_17
        && st_reg.cmd.op == `PXA_OP_COMPARE && !bus_req.wr |=> st_reg.dst_word[11:0] == 12'h000)
        else $error("compare left nonzero low nibbles");

    implicit_read_a: assert property (bus_req.rd && implicit_access_select // RULE_24
        |=> rd_data == $past(st_reg.dst_word))
        else $error("implicit read did not return destination word");

    bexp_step_a: assert property (st_reg.seq == PXA_RUN && st_reg.cmd.op == `PXA_OP_BEXP_FG // RULE_15
        && !st_reg.cmd.bpp8 && !st_reg.cmd.zoom2 && !st_reg.cmd.shrink2 && !bus_req.wr
        |=> st_reg.bit_idx == 4'($past(st_reg.bit_idx) + 4'h4))
        else $error("bit expansion index did not advance one nibble");

    packed_step_a: assert property (st_reg.seq == PXA_RUN && st_reg.cmd.op == `PXA_OP_PACKED // RULE_18
        && !st_reg.cmd.bpp8 && !bus_req.wr |=> st_reg.nib_idx == 2'($past(st_reg.nib_idx) + 2'h1))
        else $error("packed test index did not advance");

endmodule

// ---- pxa_regs.svh ----
// Register offsets, field positions, reset values and timing counts for the pixel accelerator.
// Assumes a 4-bit word-index register port; each offset below is a word index.
`ifndef PXA_REGS_SVH
`define PXA_REGS_SVH

// ----------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------
`define PXA_OFF_SRC      4'h0
`define PXA_OFF_DST      4'h1
`define PXA_OFF_CMD      4'h2
`define PXA_OFF_KEY      4'h3
`define PXA_OFF_FG       4'h4
`define PXA_OFF_BG       4'h5
`define PXA_OFF_SHIFT    4'h6
`define PXA_OFF_MASK     4'h7
`define PXA_OFF_STATUS   4'h8

// ----------------------------------------------------------------
// Operation codes in the command register, bits 3:0
// ----------------------------------------------------------------
`define PXA_OP_COPY      4'h0
`define PXA_OP_PATCH     4'h1
`define PXA_OP_EXCH      4'h2
`define PXA_OP_SWAP      4'h3
`define PXA_OP_PAINT_FG  4'h4
`define PXA_OP_PAINT_FB  4'h5
`define PXA_OP_BEXP_FG   4'h6
`define PXA_OP_BEXP_BG   4'h7
`define PXA_OP_COMPARE   4'h8
`define PXA_OP_PACKED    4'h9

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PXA_RST_WORD     16'h0000
`define PXA_RST_SHADE    8'h00
`define PXA_SLOT_BUDGET  16
`define PXA_RUN_CYCLES   1

`endif

// ---- pxa_pkg.sv ----
// Types shared by the pixel accelerator modules.
// Assumes pxa_regs.svh supplies the numeric constants.
package pxa_pkg;

    typedef enum logic {
        PXA_IDLE,
        PXA_RUN
    } pxa_seq_t;

    typedef struct packed {
        logic [6:0] spare;
        logic       src_trig;
        logic       shrink2;
        logic       zoom2;
        logic       invert;
        logic       bpp8;
        logic [3:0] op;
    } pxa_cmd_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } pxa_bus_req_t;

    typedef struct packed {
        pxa_seq_t    seq;
        logic [15:0] src_word;
        logic [15:0] dst_word;
        logic [15:0] carry_upper_half;
        logic [15:0] carry_lower_half;
        logic [15:0] hold_word;
        pxa_cmd_t    cmd;
        logic [7:0]  transparent_key_reg;
        logic [7:0]  foreground_shade_reg;
        logic [7:0]  background_shade_reg;
        logic [1:0]  shift;
        logic [15:0] mask;
        logic [3:0]  bit_idx;
        logic [1:0]  nib_idx;
        logic        half_sel;
        logic        xch_phase;
        logic [15:0] rdata;
    } pxa_state_t;

endpackage

// ---- pxa_pixel_lane.sv ----
// One pixel lane of the combine stage, 4 or 8 bits wide.
// Assumes opcodes from pxa_regs.svh; purely combinational.
`timescale 1ns/1ns
`include "pxa_regs.svh"

module pxa_pixel_lane
    import pxa_pkg::*;
#(
    parameter int W = 4
) (
    input  wire logic [3:0]   op,         // Selected operation
    input  wire logic         phase,      // Exchange phase
    input  wire logic [W-1:0] src,        // Aligned source pixel
    input  wire logic [W-1:0] dst,        // Destination pixel
    input  wire logic [W-1:0] hold,       // Held source pixel
    input  wire logic [7:0]   key,        // Transparent key colour
    input  wire logic [7:0]   fg,         // Foreground shade
    input  wire logic [7:0]   bg,         // Background shade
    input  wire logic         expbit,     // Bit for expansion
    output logic      [W-1:0] res,        // Combined pixel
    output logic              transp      // Source equals key
);
    logic hold_transp;

    always_comb begin
        // RULE_06: key compare
        transp      = (src == key[W-1:0]);
        hold_transp = (hold == key[W-1:0]);
        case (op)
            // RULE_04: plain copy
            `PXA_OP_COPY:     res = src;
            // RULE_05: patch keeps dest
            `PXA_OP_PATCH:    res = transp ? dst : src;
            // RULE_07: exchange both ways
            `PXA_OP_EXCH:     res = src;
            // RULE_08: swap skips transparent
            `PXA_OP_SWAP:     res = phase ? (hold_transp ? hold : src) : (transp ? dst : src);
            // RULE_10: foreground paint
            `PXA_OP_PAINT_FG: res = transp ? dst : fg[W-1:0];
            // RULE_11: foreground/background paint
            `PXA_OP_PAINT_FB: res = transp ? bg[W-1:0] : fg[W-1:0];
            // RULE_12: bit expand foreground
            `PXA_OP_BEXP_FG:  res = expbit ? fg[W-1:0] : dst;
            // RULE_13: bit expand background
            `PXA_OP_BEXP_BG:  res = expbit ? fg[W-1:0] : bg[W-1:0];
            default:          res = dst;
        endcase
    end

endmodule

// ---- pxa_host.sv ----
// Host CPU model: one-cycle register strobes, read data taken in the following cycle.
// Assumes the core never stalls the port and answers a read one cycle late.
`timescale 1ns/1ns
module pxa_host
    import pxa_pkg::*;
(
    input  wire logic         mclk,                   // Clock
    input  wire logic [15:0]  rd_data,                // Read data
    output pxa_bus_req_t      bus_req,                // Port request
    output logic              implicit_access_select  // Alias select
);
    initial {bus_req, implicit_access_select} = '0;
    task automatic xfer(input logic w, input logic [21:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge mclk);
        bus_req <= '{wr: w, rd: !w, addr: a[3:0], wdata: d};
        implicit_access_select <= a[21];
        @(posedge mclk);
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a[3:0], wdata: ~d};
        @(posedge mclk);
        q = rd_data;
    endtask
endmodule

// ---- test_pixel_accel_operations.sv ----
// Self-checking bench for the pixel accelerator core.
// Assumes pxa_host makes every register cycle; expected words are worked out by hand.
`timescale 1ns/1ns
`include "pxa_regs.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; $display("CHECK FAILED %0t got %h", $time, a); end end
module test_pixel_accel_operations
    import pxa_pkg::*;
;
    localparam logic [3:0] SRC = `PXA_OFF_SRC, DST = `PXA_OFF_DST, CMD = `PXA_OFF_CMD;
    logic         mclk, reset_n, pixac_busy, implicit_access_select;
    logic [15:0]  rd_data;
    pxa_bus_req_t bus_req;
    int           error_cnt = 0, n_checks = 0, cyc = 0;
    pxa_core pxa_core_inst (.mclk(mclk), .reset_n(reset_n), .bus_req(bus_req),
        .implicit_access_select(implicit_access_select), .rd_data(rd_data), .pixac_busy(pixac_busy));
    pxa_host pxa_host_inst (.mclk(mclk), .rd_data(rd_data), .bus_req(bus_req),
        .implicit_access_select(implicit_access_select));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Whole run needs about 220 cycles
    always @(posedge mclk) if (++cyc == 2000) test_done(1'b1);
    task automatic test_done(input bit hung);
        error_cnt += hung;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Write a register; with c set, read the destination word back and compare
    task automatic w(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e = 16'h0000, input bit c = 1'b0);
        logic [15:0] q;
        pxa_host_inst.xfer(1'b1, {18'h00000, a}, d, q);
        if (!c) return;
        pxa_host_inst.xfer(1'b0, {18'h00000, DST}, 16'h0000, q);
        `CHK(q, e)
    endtask
    // Key 5, foreground F, background C at 4 bits per pixel
    task automatic t_color;
        w(`PXA_OFF_KEY, 16'h0055);
        w(`PXA_OFF_FG, 16'h00FF);
        w(`PXA_OFF_BG, 16'h00CC, 16'h0000, 1);
        w(CMD, 16'h0001);
        w(SRC, 16'h5A5B);
        w(DST, 16'h1234, 16'h1A3B, 1);
        w(CMD, 16'h0004);
        w(DST, 16'h1234, 16'h1F3F, 1);
        w(CMD, 16'h0005);
        w(DST, 16'h1234, 16'hCFCF, 1);
        w(CMD, 16'h0006);
        w(SRC, 16'h1B00);
        w(DST, 16'h1234, 16'h123F, 1);
        w(DST, 16'h1234, 16'hF2FF, 1);
        w(CMD, 16'h0007);
        w(DST, 16'h1234, 16'hCCCF, 1);
        // Zoom 2 at 8 bits per pixel: one source bit paints both pixels
        w(CMD, 16'h0056);
        w(SRC, 16'hA000);
        w(DST, 16'h1234, 16'hFFFF, 1);
        w(DST, 16'h1234, 16'h1234, 1);
    endtask
    // Source-triggered operations: tests, packed nibbles, exchange
    task automatic t_source;
        w(CMD, 16'h0008);
        w(SRC, 16'h5A5B, 16'hA000, 1);
        w(CMD, 16'h0009);
        w(DST, 16'h0000);
        w(SRC, 16'h5A5B);
        w(SRC, 16'hA5A5, 16'hA500, 1);
        w(CMD, 16'h0018);
        w(SRC, 16'h55AA, 16'hA000, 1);
        w(SRC, 16'hAA55, 16'h9000, 1);
        w(CMD, 16'h0002);
        w(SRC, 16'h1111, 16'h1111, 1);
        w(SRC, 16'h2222, 16'h2222, 1);
        // Swap: transparent source pixels stay at the source on write-back
        w(CMD, 16'h0003);
        w(DST, 16'h1234);
        w(SRC, 16'h5A5B, 16'h1A3B, 1);
        w(SRC, 16'h1234, 16'h5254, 1);
    endtask
    // Copy, inverted carry order, then implicit access with shift and mask
    task automatic t_copy;
        logic [15:0] q;
        w(CMD, 16'h0000);
        w(SRC, 16'h1234);
        w(SRC, 16'h5678);
        w(DST, 16'hABCD, 16'h5678, 1);
        w(CMD, 16'h0020);
        w(SRC, 16'h9ABC);
        w(DST, 16'hABCD, 16'h1234, 1);
        w(CMD, 16'h0100);
        w(`PXA_OFF_SHIFT, 16'h0001);
        w(`PXA_OFF_MASK, 16'hFF00);
        pxa_host_inst.xfer(1'b1, 22'h200001, 16'h5678, q);
        `CHK(pixac_busy, 1'b1)
        pxa_host_inst.xfer(1'b0, 22'h200000, 16'h0000, q);
        `CHK(q, 16'h1267)
        `CHK(pixac_busy, 1'b0)
        pxa_host_inst.xfer(1'b0, 22'h00000F, 16'h0000, q);
        `CHK(q, 16'h0000)
    endtask
    initial begin
        reset_n = 1'b0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        t_color;
        t_source;
        t_copy;
        test_done(1'b0);
    end
endmodule
